/* File: fpurs_top.v */
/*
 FPU result and status control: stage-two status/product/sum registers
 with bypass, rounding on a 64-bit result, half select onto a 32-bit Y bus
 with byte parity, and exception and comparison flags.
 Assumes an AXI4-Lite master for control, and ALU and multiplier datapaths
 that present operands, raw results and their classification on ports.
*/
`timescale 1ns/1ps
`include "fpurs_regs.vh"

module fpurs_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Datapath results
    input wire [63:0] alu_result,
    input wire [63:0] mul_result,
    input wire alu_inexact,
    input wire mul_inexact,
    input wire alu_tiny,
    input wire mul_tiny,
    input wire result_wrapped,
    input wire mul_active,
    // Operand classification
    input wire a_operand_nan,
    input wire a_operand_denorm,
    input wire b_operand_nan,
    input wire b_operand_denorm,
    input wire compare_op,
    // Controller selects
    input wire [7:0] operand_source_select,
    input wire [1:0] chained_status_select,
    // Y bus three signals, parity two
    input wire [31:0] y_in,
    output reg [31:0] y_out,
    output reg y_oe,
    output reg [3:0] y_port_parity,
    output reg y_parity_oe,
    // Status flags
    output reg rounding_carry_flag,
    output reg status_origin_flag,
    output reg b_port_exception_flag,
    output reg a_port_exception_flag,
    output reg underflow_flag,
    output reg nan_compare_flag,
    // Selection seen by the datapath
    output reg [7:0] operand_select_q,
    output reg [63:0] c_register_q
);

    function [3:0] fpurs_parity;
        input [31:0] w;
        begin
            fpurs_parity = {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
        end
    endfunction

    reg [5:0] ctrl_q;
    wire bypass = ctrl_q[`FPURS_CTRL_BYPASS];
    wire [1:0] round_mode = {ctrl_q[`FPURS_CTRL_RND_HI],
                             ctrl_q[`FPURS_CTRL_RND_LO]};
    wire result_half_select = ctrl_q[`FPURS_CTRL_HALF];
    wire c_register_source_select = ctrl_q[`FPURS_CTRL_CSRC];
    wire y_bus_drive_enable_n = ctrl_q[`FPURS_CTRL_OEN];

    // Chained selection overrides the current unit
    reg use_mul;
    always @* begin
        case (chained_status_select)
            2'h1: use_mul = 1'b0;
            2'h2: use_mul = 1'b1;
            default: use_mul = mul_active;
        endcase
    end

    // Rounding: guard bit is bit 0 of the 64-bit result, bit 1 is the LSB, no sticky bit
    reg [63:0] raw;
    reg sign;
    reg rnd_up;
    reg [63:0] rounded;
    always @* begin
        raw = use_mul ? mul_result : alu_result;
        sign = raw[63];
        case (round_mode)
            `FPURS_RND_NEAR: rnd_up = raw[0] & raw[1];
            `FPURS_RND_ZERO: rnd_up = 1'b0;
            `FPURS_RND_PINF: rnd_up = ~sign & raw[0];
            `FPURS_RND_MINF: rnd_up = sign & raw[0];
            default: rnd_up = 1'b0;
        endcase
        rounded = raw + {63'h0, rnd_up};
    end

    // Next status and product/sum values
    wire [5:0] stat_d = {
        compare_op & (a_operand_nan | b_operand_nan),
        use_mul ? (mul_inexact & mul_tiny)
                : (alu_inexact & alu_tiny),
        a_operand_nan | a_operand_denorm,
        b_operand_nan | b_operand_denorm,
        use_mul,
        result_wrapped & rnd_up};
    reg [5:0] stat_q;
    reg [63:0] prod_q;
    reg [63:0] sum_q;

    // Flowthrough picks combinational values; data regs ignore reset
    wire [5:0] stat_v = bypass ? stat_d : stat_q;
    wire [63:0] prod_v = bypass ? rounded : prod_q;
    wire [63:0] sum_v = bypass ? rounded : sum_q;
    wire [63:0] result_v = use_mul ? prod_v : sum_v;
    wire [31:0] y_word = result_half_select ? result_v[63:32]
                                            : result_v[31:0];

    always @(posedge aclk) begin
        if (use_mul)
            prod_q <= rounded;
        else
            sum_q <= rounded;
        c_register_q <= c_register_source_select ? prod_v : sum_v;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= 6'h00;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Pin outputs registered; adds one cycle after the bypass mux
    always @(posedge aclk) begin
        if (!aresetn) begin
            y_out <= 32'h0;
            y_oe <= 1'b0;
            y_port_parity <= 4'h0;
            y_parity_oe <= 1'b0;
            rounding_carry_flag <= 1'b0;
            status_origin_flag <= 1'b0;
            b_port_exception_flag <= 1'b0;
            a_port_exception_flag <= 1'b0;
            underflow_flag <= 1'b0;
            nan_compare_flag <= 1'b0;
            operand_select_q <= 8'h00;
        end else begin
            y_out <= y_word;
            y_oe <= ~y_bus_drive_enable_n;
            y_port_parity <= fpurs_parity(y_word);
            y_parity_oe <= ~y_bus_drive_enable_n;
            rounding_carry_flag <= stat_v[`FPURS_ST_RNDC];
            status_origin_flag <= stat_v[`FPURS_ST_ORIG];
            b_port_exception_flag <= stat_v[`FPURS_ST_EXB];
            a_port_exception_flag <= stat_v[`FPURS_ST_EXA];
            underflow_flag <= stat_v[`FPURS_ST_UNDER];
            nan_compare_flag <= stat_v[`FPURS_ST_NAN_COMPARE_FLAG];
            operand_select_q <= operand_source_select;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    reg aw_hold_q;
    reg w_hold_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_ok = aw_hold_q | (s_axi_awvalid & s_axi_awready);
    wire w_ok = w_hold_q | (s_axi_wvalid & s_axi_wready);
    wire [3:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
    wire do_write = aw_ok & w_ok & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FPURS_RESP_OK;
            ctrl_q <= `FPURS_CTRL_RST;
        end else begin
            s_axi_awready <= ~aw_ok & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_ok & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa == `FPURS_CTRL_OFF) begin
                    s_axi_bresp <= `FPURS_RESP_OK;
                    if (ws[0])
                        ctrl_q <= wd[5:0];
                end else if (wa == `FPURS_STAT_OFF ||
                             wa == `FPURS_RESH_OFF ||
                             wa == `FPURS_RESL_OFF) begin
                    s_axi_bresp <= `FPURS_RESP_OK;
                end else begin
                    s_axi_bresp <= `FPURS_RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FPURS_RESP_OK;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `FPURS_RESP_OK;
                case (s_axi_araddr)
                    `FPURS_CTRL_OFF: s_axi_rdata <= {26'h0, ctrl_q};
                    `FPURS_STAT_OFF: s_axi_rdata <= {26'h0, stat_v};
                    `FPURS_RESH_OFF: s_axi_rdata <= result_v[63:32];
                    `FPURS_RESL_OFF: s_axi_rdata <= result_v[31:0];
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `FPURS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // fpurs_top

/* File: fpurs_regs.vh */
/*
 Constants for the FPU result and status control block: register map,
 field positions, reset values and rounding mode codes.
 Assumes inclusion by the single design file fpurs_top.v.
*/
`ifndef FPURS_REGS_VH
`define FPURS_REGS_VH

// Register byte offsets
`define FPURS_CTRL_OFF 4'h0
`define FPURS_STAT_OFF 4'h4
`define FPURS_RESH_OFF 4'h8
`define FPURS_RESL_OFF 4'hC

// Control field positions
`define FPURS_CTRL_BYPASS 0
`define FPURS_CTRL_RND_LO 1
`define FPURS_CTRL_RND_HI 2
`define FPURS_CTRL_HALF 3
`define FPURS_CTRL_CSRC 4
`define FPURS_CTRL_OEN 5
`define FPURS_CTRL_RST 6'h20

// Status field positions
`define FPURS_ST_RNDC 0
`define FPURS_ST_ORIG 1
`define FPURS_ST_EXB 2
`define FPURS_ST_EXA 3
`define FPURS_ST_UNDER 4
`define FPURS_ST_NAN_COMPARE_FLAG 5

// Rounding modes
`define FPURS_RND_NEAR 2'h0
`define FPURS_RND_ZERO 2'h1
`define FPURS_RND_PINF 2'h2
`define FPURS_RND_MINF 2'h3

// Bus responses
`define FPURS_RESP_OK 2'h0
`define FPURS_RESP_SLVERR 2'h2

`endif

/* File: fpurs_asserts.sv */
/*
 Port checker for fpurs_top: bus answers, parity and status flags.
 Assumes binding to every fpurs_top, signal names equal to its ports.
*/
`timescale 1ns/1ps
module fpurs_asserts (
    // Clock and bus
    input wire aclk,
    input wire aresetn,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Y bus
    input wire [31:0] y_out,
    input wire y_oe,
    input wire [3:0] y_port_parity,
    // Flags and causes
    input wire a_port_exception_flag,
    input wire a_operand_nan,
    input wire a_operand_denorm,
    input wire nan_compare_flag,
    input wire compare_op,
    input wire b_operand_nan,
    input wire underflow_flag,
    input wire alu_inexact,
    input wire alu_tiny,
    input wire mul_inexact,
    input wire mul_tiny
);
    // Causes as nets, so that $past sees plain signals
    wire a_bad = a_operand_nan | a_operand_denorm;
    wire cmp_nan = compare_op & (a_operand_nan | b_operand_nan);
    wire tiny_x = (alu_inexact & alu_tiny) | (mul_inexact & mul_tiny);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_y_parity: assert property (y_oe |-> y_port_parity ==
        {^y_out[31:24], ^y_out[23:16], ^y_out[15:8], ^y_out[7:0]})
        else $error("Y parity wrong");
    a_reset_clear: assert property ($rose(aresetn) |-> !y_oe
        && !nan_compare_flag && !underflow_flag && !a_port_exception_flag)
        else $error("state left after reset");
    a_aexc_cause: assert property (a_port_exception_flag |->
        $past(a_bad) || $past(a_bad, 2)) else $error("A flag without cause");
    a_aexc_raise: assert property (a_bad [*3] |-> a_port_exception_flag)
        else $error("A flag missing");
    a_nan_compare_flag_cause: assert property (nan_compare_flag |->
        $past(cmp_nan) || $past(cmp_nan, 2)) else $error("unordered spurious");
    a_nan_compare_flag_raise: assert property (cmp_nan [*3] |-> nan_compare_flag)
        else $error("unordered missing");
    a_under_cause: assert property (underflow_flag |->
        $past(tiny_x) || $past(tiny_x, 2)) else $error("underflow spurious");
endmodule // fpurs_asserts

bind fpurs_top fpurs_asserts chk_u (.*);

/* File: fpurs_partner.sv */
/*
 Far-side datapath and sequencer model feeding fpurs_top.
 Assumes the bench steps mode just after a clock edge.
*/
`timescale 1ns/1ps
module fpurs_partner #(
    parameter logic [63:0] ALU_V = 64'h4009_21FB_5444_2D00,
    parameter logic [63:0] MUL_V = 64'hC005_BF0A_8B14_5700
) (
    // Scenario
    input wire [1:0] mode,
    // Datapath outputs
    output logic [63:0] alu_result,
    output logic [63:0] mul_result,
    output logic alu_inexact,
    output logic mul_inexact,
    output logic alu_tiny,
    output logic mul_tiny,
    output logic result_wrapped,
    output logic mul_active,
    output logic a_operand_nan,
    output logic a_operand_denorm,
    output logic b_operand_nan,
    output logic b_operand_denorm,
    output logic compare_op,
    output logic [7:0] operand_source_select,
    output logic [1:0] chained_status_select
);
    // Guard bit zero, so no rounding mode alters the results
    always_comb begin
        {alu_inexact, mul_inexact, alu_tiny, mul_tiny} = 4'h0;
        {result_wrapped, mul_active, compare_op} = 3'h0;
        {a_operand_nan, a_operand_denorm} = 2'h0;
        {b_operand_nan, b_operand_denorm} = 2'h0;
        alu_result = ALU_V;
        mul_result = MUL_V;
        operand_source_select = 8'hA5;
        chained_status_select = 2'h0;
        case (mode)
            2'h1: {a_operand_nan, b_operand_denorm, compare_op} = 3'h7;
            2'h2: {mul_active, mul_inexact, mul_tiny} = 3'h7;
            2'h3: {mul_active, chained_status_select} = 3'h5;
            default: ;
        endcase
    end
endmodule // fpurs_partner

/* File: fpurs_top_test.sv */
/*
 Self-checking bench for fpurs_top over AXI4-Lite with a datapath model.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module fpurs_top_test;
    localparam logic [63:0] ALU_V = 64'h4009_21FB_5444_2D00;
    localparam logic [63:0] MUL_V = 64'hC005_BF0A_8B14_5700;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [1:0] mode = 0, rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, y_oe, y_parity_oe, mul_active, result_wrapped;
    wire [1:0] s_axi_bresp, s_axi_rresp, chained_status_select;
    wire [31:0] s_axi_rdata, y_out, y_in;
    wire [63:0] alu_result, mul_result, c_register_q;
    wire [7:0] operand_source_select, operand_select_q;
    wire [3:0] y_port_parity;
    wire alu_inexact, mul_inexact, alu_tiny, mul_tiny, compare_op;
    wire a_operand_nan, a_operand_denorm, b_operand_nan, b_operand_denorm;
    wire rounding_carry_flag, status_origin_flag, b_port_exception_flag;
    wire a_port_exception_flag, underflow_flag, nan_compare_flag;
    int fail_count = 0, tests_run = 0;
    // Released bus must not look like the last value
    assign y_in = y_oe ? y_out : ~y_out;
    fpurs_top dut_u (.*);
    fpurs_partner #(.ALU_V(ALU_V), .MUL_V(MUL_V)) far_u (.*);
    always #10 aclk = ~aclk;
    task automatic chk(input logic [63:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic step(input logic [1:0] m);
        @(posedge aclk);
        mode <= m;
        cyc(3);
    endtask
    // Flag latency with stage registers clocked or transparent
    task automatic lat(input logic byp);
        axw(4'h0, {31'h0, byp});
        step(2'h0);
        @(posedge aclk);
        mode <= 2'h1;
        cyc(1);
        chk(a_port_exception_flag, byp, "first edge");
        cyc(1);
        chk(a_port_exception_flag, 1, "second edge");
    endtask
    task results;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        results;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axr(4'h0);
        chk(rd, 32'h20, "ctrl reset");
        chk(y_oe, 0, "Y off");
        axr(4'h6);
        chk(rsp, 2'h2, "unmapped read");
        axw(4'h6, 32'h3F);
        chk(rsp, 2'h2, "unmapped write");
        axw(4'h4, 32'h3F);
        chk(rsp, 2'h0, "status write okay");
        axr(4'h4);
        chk(rd, 0, "status read only");
        $display("test registers done");
        step(2'h1);
        chk({a_port_exception_flag, b_port_exception_flag}, 3, "ex");
        chk(nan_compare_flag, 1, "unordered");
        step(2'h2);
        chk({underflow_flag, status_origin_flag}, 3, "mul");
        step(2'h3);
        chk(status_origin_flag, 0, "forced alu");
        step(2'h0);
        $display("test flags done");
        // Every rounding mode on an exact result
        for (int m = 0; m < 4; m++) begin
            axw(4'h0, 32'(m * 2));
            cyc(3);
            chk(y_out, ALU_V[31:0], "lower half");
        end
        chk(y_oe, 1, "Y on");
        chk(y_parity_oe, 1, "parity on");
        chk(y_port_parity, {^ALU_V[31:24], ^ALU_V[23:16],
            ^ALU_V[15:8], ^ALU_V[7:0]}, "parity");
        chk(operand_select_q, 8'hA5, "operand select");
        chk(rounding_carry_flag, 0, "no carry");
        axw(4'h0, 32'h08);
        cyc(3);
        chk(y_out, ALU_V[63:32], "upper half");
        axw(4'h0, 32'h10);
        cyc(2);
        chk(c_register_q, MUL_V, "C from mul");
        axw(4'h0, 32'h00);
        cyc(2);
        chk(c_register_q, ALU_V, "C from alu");
        $display("test datapath done");
        lat(1'b1);
        lat(1'b0);
        $display("test bypass done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(1);
        chk(c_register_q, ALU_V, "C kept");
        chk(a_port_exception_flag, 0, "flag cleared");
        $display("test reset done");
        results;
    end
endmodule // fpurs_top_test
